// ---- hw/sea_pkg.sv ----
package sea_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the Avalon slave)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_LIMIT = 4'h0; // Stack limit boundary
    localparam logic [3:0] OFS_SP = 4'h4; // Stack pointer window
    localparam logic [3:0] OFS_CTRL = 4'h8; // Secure RAM enables
    localparam logic [3:0] OFS_STAT = 4'hc; // Sticky event flags

    // Field positions
    localparam int CTRL_BOOT_EN = 0; // Boot secure RAM gate on
    localparam int CTRL_SEC_EN = 1; // Secure segment RAM gate on
    localparam int STAT_OVF = 0; // Stack overflow seen
    localparam int STAT_UDF = 1; // Stack underflow seen
    localparam int STAT_REF = 2; // Secure access refused
    localparam int STAT_W = 3; // Width of status field

    // ------------------------------------------------------------
    // Reset values and address constants
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [15:0] DEFAULT_WORKING_REG_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0800; // First word past SFRs
    localparam logic [15:0] SFR_TOP = 16'h0800; // Stack floor
    localparam logic [15:0] NEAR_MASK = 16'h1fff; // 13-bit near space
    localparam logic [15:0] PUSH_STEP = 16'h0002; // One word per push
    localparam logic [15:0] BOOT_RAM_LO = 16'h0c00;
    localparam logic [15:0] BOOT_RAM_HI = 16'h0cff;
    localparam logic [15:0] SEC_RAM_LO = 16'h0d00;
    localparam logic [15:0] SEC_RAM_HI = 16'h0dff;
    localparam logic [3:0] SP_SEL = 4'hf; // Stack pointer index
    localparam logic [3:0] WREG0_SEL = 4'h0; // Default working reg

    // ------------------------------------------------------------
    // Operations presented by the decoder
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_FILE = 4'h1, // File register direct
        OP_REG = 4'h2, // Register direct operand
        OP_LIT5 = 4'h3, // Short literal operand
        OP_LIT10 = 4'h4, // Long literal operand
        OP_IND = 4'h5, // Register indirect
        OP_POST = 4'h6, // Indirect, post-modified
        OP_PRE = 4'h7, // Indirect, pre-modified
        OP_INDEX = 4'h8, // Base plus offset register
        OP_LITOFF = 4'h9, // Base plus literal
        OP_PUSH = 4'ha, // Plain word push
        OP_POP = 4'hb, // Plain word pop
        OP_PUSH_CALL = 4'hc, // Upper PC push from a call
        OP_PUSH_EXC = 4'hd // Upper PC push from an exception
    } sea_op_t;

    // True when the address is formed from the stack pointer
    function automatic logic uses_sp(sea_op_t op, logic [3:0] sel);
        logic stack_op;
        stack_op = (op == OP_PUSH) || (op == OP_POP) ||
                   (op == OP_PUSH_CALL) || (op == OP_PUSH_EXC);
        return stack_op || ((op >= OP_IND) && (op <= OP_LITOFF) &&
                            (sel == SP_SEL));
    endfunction

endpackage

// ---- hw/sea_addr_chk.sv ----
`timescale 1ns/1ps

module sea_addr_chk (
    // Address under test
    input wire logic [15:0] ea_i,
    input wire logic sp_based_i,
    input wire logic mem_access_i,
    // Limits and gates
    input wire logic [15:0] limit_i,
    input wire logic boot_en_i,
    input wire logic sec_en_i,
    // Where the running code sits
    input wire logic code_in_boot_i,
    input wire logic code_in_secure_i,
    // Verdicts
    output logic overflow_o,
    output logic underflow_o,
    output logic refused_o
);

    logic in_boot; // Address inside boot secure RAM
    logic in_sec; // Address inside secure segment RAM

    // ------------------------------------------------------------
    // Stack bounds and secure segment gating
    // ------------------------------------------------------------
    always_comb begin
        in_boot = (ea_i >= sea_pkg::BOOT_RAM_LO) &&
                  (ea_i <= sea_pkg::BOOT_RAM_HI);
        in_sec = (ea_i >= sea_pkg::SEC_RAM_LO) &&
                 (ea_i <= sea_pkg::SEC_RAM_HI);
        // Equal to the limit is still legal, one word past is not
        overflow_o = sp_based_i && (ea_i > limit_i); // R07 R08
        underflow_o = sp_based_i && (ea_i < sea_pkg::SFR_TOP); // R09
        refused_o = mem_access_i &&
                    ((boot_en_i && in_boot && !code_in_boot_i) || // R11
                     (sec_en_i && in_sec && !code_in_secure_i)); // R12
    end

endmodule

// ---- hw/sea_stack_ea.sv ----
// Functional notes
// R01: Stack pointer marks first free word, grows up
// R02: Push writes then increments; pop decrements first
// R03: Call pushes upper PC with top bit clear
// R04: Exception push puts status byte above PC
// R05: Stack limit bit zero always reads zero
// R06: Stack limit has no reset value
// R07: Every stack-pointer address checked against limit
// R08: Push at limit fine, next one traps
// R09: Stack address below 0x0800 traps
// R10: Software avoids stack read right after limit write
// R11: Boot secure RAM only from boot code
// R12: Secure segment RAM only from secure code
// R13: File address is 13 bits, near space
// R14: File result to same register or register zero
// R15: Move reaches the whole data space
// R16: First operand direct; second register, memory, literal
// R17: Indirect modes plus 5 or 10 bit literals
// R18: Indirect uses base pointer unchanged
// R19: Post-modify uses base, then steps pointer
// R20: Pre-modify steps pointer, uses new value
// R21: Indexed address is base plus offset register
// R22: Literal offset address is base plus literal
// R23: Stack error is one-cycle trap with address
`timescale 1ns/1ps

module sea_stack_ea (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Address request from the decoder
    input wire logic req_valid_i,
    input wire sea_pkg::sea_op_t op_i,
    input wire logic mem_write_i,
    input wire logic move_full_i,
    input wire logic [15:0] file_addr_i,
    input wire logic [3:0] base_sel_i,
    input wire logic [3:0] index_sel_i,
    input wire logic [3:0] src1_sel_i,
    input wire logic [3:0] modify_i,
    input wire logic [9:0] literal_i,
    input wire logic [15:0] push_data_i,
    input wire logic [23:0] pc_i,
    input wire logic [7:0] status_low_i,
    input wire logic code_in_boot_i,
    input wire logic code_in_secure_i,
    // Result writeback into the working registers
    input wire logic wb_valid_i,
    input wire logic wb_to_wreg0_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [15:0] wb_data_i,
    // Data memory side
    output logic [15:0] ea_o,
    output logic mem_rd_o,
    output logic mem_we_o,
    output logic [15:0] mem_wdata_o,
    // Operands and exceptions
    output logic [15:0] operand1_o,
    output logic [15:0] operand2_o,
    output logic stack_trap_o,
    output logic refused_o
);

    logic [1:0] rst_sync_q; // Reset release chain
    logic rst_b; // Synchronised reset, active low
    logic [15:0] default_working_reg_q [16]; // Working registers, last is stack ptr
    logic [15:0] limit_q; // Stack limit boundary
    logic [1:0] ctrl_q; // Secure RAM gate enables
    logic [sea_pkg::STAT_W-1:0] stat_q; // Sticky event flags
    logic wait_q; // Waitrequest, high while idle
    logic bus_wr; // Write accepted this edge
    logic [31:0] rd_mux; // Read data before capture
    logic [15:0] base; // Selected base pointer
    logic [15:0] sp; // Current stack pointer
    logic [15:0] mod16; // Sign-extended pointer step
    logic [15:0] ea_d; // Effective address this cycle
    logic rd_d; // Memory read wanted
    logic we_d; // Memory write wanted
    logic [15:0] wdata_d; // Memory write data
    logic [15:0] op2_d; // Second operand value
    logic ptr_we; // Pointer update wanted
    logic [3:0] ptr_sel; // Pointer being updated
    logic [15:0] ptr_val; // New pointer value
    logic sp_based; // Address derived from stack pointer
    logic ovf; // Above the stack limit
    logic udf; // Below the stack floor
    logic refused; // Boot or secure segment RAM refusal
    logic trap_d; // Stack error this cycle

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Two flops so release never lands near an edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    // ------------------------------------------------------------
    // Avalon slave handshake
    // ------------------------------------------------------------
    // One wait cycle per access; waitrequest drops for one edge
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((avs_read_i || avs_write_i) && wait_q);
        end
    end
    assign avs_waitrequest_o = wait_q;
    assign bus_wr = avs_write_i && !wait_q;

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_i)
            sea_pkg::OFS_LIMIT: rd_mux[15:0] = {limit_q[15:1], 1'b0}; // R05
            sea_pkg::OFS_SP: rd_mux[15:0] = default_working_reg_q[sea_pkg::SP_SEL];
            sea_pkg::OFS_CTRL: rd_mux[1:0] = ctrl_q;
            sea_pkg::OFS_STAT: rd_mux[sea_pkg::STAT_W-1:0] = stat_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Captured during the wait cycle so it stands at completion
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && wait_q) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Stack limit boundary
    // ------------------------------------------------------------
    // No reset: the limit is meaningless until software sets it.
    // Bit 0 is forced low so the boundary stays word aligned.
    always_ff @(posedge clk_i) begin
        if (bus_wr && avs_address_i == sea_pkg::OFS_LIMIT) begin // R06
            if (avs_byteenable_i[0]) begin
                limit_q[7:0] <= {avs_writedata_i[7:1], 1'b0}; // R05
            end
            if (avs_byteenable_i[1]) begin
                limit_q[15:8] <= avs_writedata_i[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Control and status
    // ------------------------------------------------------------
    // Secure RAM enables
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= sea_pkg::CTRL_RESET;
        end else if (bus_wr && avs_address_i == sea_pkg::OFS_CTRL &&
                     avs_byteenable_i[0]) begin
            ctrl_q <= avs_writedata_i[1:0];
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= '0;
        end else begin
            if (bus_wr && avs_address_i == sea_pkg::OFS_STAT &&
                avs_byteenable_i[0]) begin
                stat_q <= stat_q & ~avs_writedata_i[sea_pkg::STAT_W-1:0];
            end
            if (req_valid_i && ovf) begin
                stat_q[sea_pkg::STAT_OVF] <= 1'b1;
            end
            if (req_valid_i && udf) begin
                stat_q[sea_pkg::STAT_UDF] <= 1'b1;
            end
            if (req_valid_i && refused) begin
                stat_q[sea_pkg::STAT_REF] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Effective address generation
    // ------------------------------------------------------------
    always_comb begin
        base = default_working_reg_q[base_sel_i];
        sp = default_working_reg_q[sea_pkg::SP_SEL];
        mod16 = {{12{modify_i[3]}}, modify_i};
        ea_d = 16'h0000;
        rd_d = 1'b0;
        we_d = 1'b0;
        wdata_d = push_data_i;
        op2_d = 16'h0000;
        ptr_we = 1'b0;
        ptr_sel = base_sel_i;
        ptr_val = base;
        unique case (op_i)
            sea_pkg::OP_NONE: begin
                ea_d = 16'h0000;
            end
            sea_pkg::OP_FILE: begin
                // Near space unless a move asks for all of it
                ea_d = move_full_i ? file_addr_i : // R15
                       (file_addr_i & sea_pkg::NEAR_MASK); // R13
                rd_d = !mem_write_i;
                we_d = mem_write_i;
            end
            sea_pkg::OP_REG: begin
                op2_d = base; // R16
            end
            sea_pkg::OP_LIT5: begin
                op2_d = {11'h000, literal_i[4:0]}; // R16 R17
            end
            sea_pkg::OP_LIT10: begin
                op2_d = {6'h00, literal_i}; // R17
            end
            sea_pkg::OP_IND: begin
                ea_d = base; // R18
                rd_d = !mem_write_i;
                we_d = mem_write_i;
            end
            sea_pkg::OP_POST: begin
                ea_d = base; // R19
                ptr_we = 1'b1;
                ptr_val = base + mod16;
                rd_d = !mem_write_i;
                we_d = mem_write_i;
            end
            sea_pkg::OP_PRE: begin
                ea_d = base + mod16; // R20
                ptr_we = 1'b1;
                ptr_val = base + mod16;
                rd_d = !mem_write_i;
                we_d = mem_write_i;
            end
            sea_pkg::OP_INDEX: begin
                ea_d = base + default_working_reg_q[index_sel_i]; // R21
                rd_d = !mem_write_i;
                we_d = mem_write_i;
            end
            sea_pkg::OP_LITOFF: begin
                ea_d = base + {{6{literal_i[9]}}, literal_i}; // R22
                rd_d = !mem_write_i;
                we_d = mem_write_i;
            end
            sea_pkg::OP_PUSH, sea_pkg::OP_PUSH_CALL,
            sea_pkg::OP_PUSH_EXC: begin
                // Write at the free word, then step past it
                ea_d = sp; // R01 R02
                we_d = 1'b1;
                ptr_we = 1'b1;
                ptr_sel = sea_pkg::SP_SEL;
                ptr_val = sp + sea_pkg::PUSH_STEP;
                if (op_i == sea_pkg::OP_PUSH_CALL) begin
                    wdata_d = {8'h00, pc_i[23:16]}; // R03
                end else if (op_i == sea_pkg::OP_PUSH_EXC) begin
                    wdata_d = {status_low_i, pc_i[23:16]}; // R04
                end
            end
            sea_pkg::OP_POP: begin
                // Step back first, then read the last used word
                ea_d = sp - sea_pkg::PUSH_STEP; // R02
                rd_d = 1'b1;
                ptr_we = 1'b1;
                ptr_sel = sea_pkg::SP_SEL;
                ptr_val = sp - sea_pkg::PUSH_STEP;
            end
            default: begin
                ea_d = 16'h0000;
            end
        endcase
        if (!req_valid_i) begin
            rd_d = 1'b0;
            we_d = 1'b0;
            ptr_we = 1'b0;
        end
    end

    assign sp_based = req_valid_i && sea_pkg::uses_sp(op_i, base_sel_i);
    assign trap_d = req_valid_i && (ovf || udf);

    sea_addr_chk u_chk (
        .ea_i(ea_d),
        .sp_based_i(sp_based),
        .mem_access_i(rd_d || we_d),
        .limit_i(limit_q),
        .boot_en_i(ctrl_q[sea_pkg::CTRL_BOOT_EN]),
        .sec_en_i(ctrl_q[sea_pkg::CTRL_SEC_EN]),
        .code_in_boot_i(code_in_boot_i),
        .code_in_secure_i(code_in_secure_i),
        .overflow_o(ovf),
        .underflow_o(udf),
        .refused_o(refused)
    );

    // ------------------------------------------------------------
    // Working registers and stack pointer
    // ------------------------------------------------------------
    // Pointer updates win over writeback, which wins over the bus.
    // Software should not move the pointer while requests flow.
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 16; i++) begin
                default_working_reg_q[i] <= (i == 15) ? sea_pkg::SP_RESET :
                             sea_pkg::DEFAULT_WORKING_REG_RESET;
            end
        end else begin
            if (bus_wr && avs_address_i == sea_pkg::OFS_SP &&
                avs_byteenable_i[1:0] == 2'h3) begin
                default_working_reg_q[sea_pkg::SP_SEL] <= {avs_writedata_i[15:1], 1'b0};
            end
            if (wb_valid_i) begin
                // File results land in register zero or in place
                default_working_reg_q[wb_to_wreg0_i ? sea_pkg::WREG0_SEL : wb_sel_i]
                    <= wb_data_i; // R14
            end
            if (ptr_we) begin
                default_working_reg_q[ptr_sel] <= ptr_val; // R19 R20 R02
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs to memory and exception logic
    // ------------------------------------------------------------
    // Trap leaves with its address in the same cycle
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            ea_o <= 16'h0000;
            mem_rd_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_wdata_o <= 16'h0000;
            operand1_o <= 16'h0000;
            operand2_o <= 16'h0000;
            stack_trap_o <= 1'b0;
            refused_o <= 1'b0;
        end else begin
            ea_o <= ea_d;
            // Refused accesses never reach memory
            mem_rd_o <= rd_d && !refused; // R11 R12
            mem_we_o <= we_d && !refused;
            mem_wdata_o <= wdata_d;
            operand1_o <= default_working_reg_q[src1_sel_i]; // R16
            operand2_o <= op2_d;
            stack_trap_o <= trap_d; // R23
            refused_o <= req_valid_i && refused;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_push_step: assert property ( // R02
        @(posedge clk_i) disable iff (!rst_b)
        req_valid_i && op_i == sea_pkg::OP_PUSH
        |=> default_working_reg_q[15] == $past(default_working_reg_q[15]) + 16'h0002 &&
            ea_o == $past(default_working_reg_q[15]) && mem_we_o == !refused_o)
        else $error("push did not write then increment");

    chk_pop_order: assert property ( // R02
        @(posedge clk_i) disable iff (!rst_b)
        req_valid_i && op_i == sea_pkg::OP_POP
        |=> ea_o == default_working_reg_q[15] && mem_rd_o == !refused_o &&
            ea_o == $past(default_working_reg_q[15]) - 16'h0002)
        else $error("pop did not decrement before read");

    chk_call_msb: assert property ( // R03
        @(posedge clk_i) disable iff (!rst_b)
        req_valid_i && op_i == sea_pkg::OP_PUSH_CALL
        |=> !mem_wdata_o[15] && mem_wdata_o[7:0] == $past(pc_i[23:16]))
        else $error("call push upper bit not clear");

    chk_exc_status: assert property ( // R04
        @(posedge clk_i) disable iff (!rst_b)
        req_valid_i && op_i == sea_pkg::OP_PUSH_EXC
        |=> mem_wdata_o == {$past(status_low_i), $past(pc_i[23:16])})
        else $error("exception push lost status byte");

    chk_limit_bit0: assert property ( // R05
        @(posedge clk_i) disable iff (!rst_b)
        avs_read_i && !wait_q && avs_address_i == sea_pkg::OFS_LIMIT
        |-> !avs_readdata_o[0])
        else $error("limit bit zero read as one");

    chk_trap_limit: assert property ( // R08
        @(posedge clk_i) disable iff (!rst_b)
        req_valid_i && op_i == sea_pkg::OP_PUSH &&
        default_working_reg_q[15] == limit_q && default_working_reg_q[15] >= 16'h0800
        |=> !stack_trap_o ##0 $past(op_i) == sea_pkg::OP_PUSH)
        else $error("push at limit raised a trap");

    chk_trap_over: assert property ( // R07 R23
        @(posedge clk_i) disable iff (!rst_b)
        sp_based && ea_d > limit_q |=> stack_trap_o)
        else $error("stack overflow missed");

    chk_trap_under: assert property ( // R09
        @(posedge clk_i) disable iff (!rst_b)
        sp_based && ea_d < 16'h0800 |=> stack_trap_o)
        else $error("stack underflow missed");

    chk_boot_gate: assert property ( // R11
        @(posedge clk_i) disable iff (!rst_b)
        (rd_d || we_d) && ctrl_q[0] && !code_in_boot_i &&
        ea_d >= 16'h0c00 && ea_d <= 16'h0cff
        |=> refused_o && !mem_rd_o && !mem_we_o)
        else $error("boot secure RAM not refused");

    chk_index_sum: assert property ( // R21
        @(posedge clk_i) disable iff (!rst_b)
        req_valid_i && op_i == sea_pkg::OP_INDEX
        |=> ea_o == $past(default_working_reg_q[base_sel_i]) + $past(default_working_reg_q[index_sel_i]))
        else $error("indexed address wrong");

endmodule

// ---- tb/sea_mem_model.sv ----
`timescale 1ns/1ps
module sea_mem_model (
    // Data memory port
    input wire logic clk_i,
    input wire logic [15:0] ea_i,
    input wire logic we_i,
    input wire logic [15:0] wdata_i
);
    // Sparse word store, so only touched words exist
    logic [15:0] mem [int];
    // Write sampled at the edge that ends the strobe cycle
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[ea_i] = wdata_i;
        end
    end
endmodule

// ---- tb/sea_stack_ea_bench.sv ----
`timescale 1ns/1ps
module sea_stack_ea_bench;
    logic clk_i = 0, rst_b_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic req_valid_i = 0, wb_valid_i = 0, move_full_i = 0;
    logic code_in_boot_i = 0, mem_write_i = 0, code_in_secure_i = 0;
    logic [3:0] avs_address_i = 4'h0, base_sel_i = 4'h0, modify_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic [9:0] literal_i = 10'h0;
    logic [15:0] wb_data_i = 16'h0, file_addr_i = 16'h0;
    logic [15:0] push_data_i = 16'h0, ea_o, mem_wdata_o, q;
    logic [15:0] operand1_o, operand2_o;
    logic [23:0] pc_i = 24'h0;
    logic [7:0] status_low_i = 8'h0;
    logic avs_waitrequest_o, mem_rd_o, mem_we_o, stack_trap_o, refused_o;
    sea_pkg::sea_op_t op_i = sea_pkg::OP_NONE;
    int miscompares = 0, compares = 0, cyc = 0;

    // Index reg 4 and first operand reg 3 fixed
    sea_stack_ea DUT (.*, .avs_byteenable_i(4'hf), .index_sel_i(4'h4),
        .src1_sel_i(4'h3), .wb_to_wreg0_i(1'b0));
    sea_mem_model MEM (.clk_i(clk_i), .ea_i(ea_o), .we_i(mem_we_o),
        .wdata_i(mem_wdata_o));

    always #12.5 clk_i = ~clk_i;
    // Hang guard, far above the roughly 120 cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            print_verdict;
        end
    end

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    // Avalon access; held until an edge samples waitrequest low
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {16'h0, d};
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[15:0];
        avs_write_i <= 0;
        avs_read_i <= 0;
    endtask

    task wb(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk_i);
        wb_sel_i <= s;
        wb_data_i <= d;
        wb_valid_i <= 1;
        @(posedge clk_i);
        wb_valid_i <= 0;
    endtask

    // One request; outputs judged in the cycle they stand
    task rq(input sea_pkg::sea_op_t o, input logic [3:0] b, m,
            input logic [9:0] l, input logic [15:0] e, input logic we, rd, t);
        @(posedge clk_i);
        op_i <= o;
        base_sel_i <= b;
        modify_i <= m;
        literal_i <= l;
        req_valid_i <= 1;
        @(posedge clk_i);
        req_valid_i <= 0;
        @(posedge clk_i);
        chk("ea", e, ea_o);
        chk("we", we, mem_we_o);
        chk("rd", rd, mem_rd_o);
        chk("trap", t, stack_trap_o);
    endtask

    task t_regs;
        bus(1, sea_pkg::OFS_LIMIT, 16'h0bff);
        bus(0, sea_pkg::OFS_LIMIT, 16'h0);
        chk("limit", 16'h0bfe, q);
        bus(0, sea_pkg::OFS_SP, 16'h0);
        chk("sp", sea_pkg::SP_RESET, q);
        bus(0, 4'h2, 16'h0);
        chk("unmapped", 16'h0, q);
        $display("done regs");
    endtask

    task t_stack;
        push_data_i <= 16'hbeef;
        pc_i <= 24'h123456;
        status_low_i <= 8'ha5;
        rq(sea_pkg::OP_PUSH, 0, 0, 0, 16'h0800, 1, 0, 0);
        rq(sea_pkg::OP_PUSH_CALL, 0, 0, 0, 16'h0802, 1, 0, 0);
        chk("call", 16'h0012, mem_wdata_o);
        rq(sea_pkg::OP_PUSH_EXC, 0, 0, 0, 16'h0804, 1, 0, 0);
        chk("exc", 16'ha512, mem_wdata_o);
        rq(sea_pkg::OP_POP, 0, 0, 0, 16'h0804, 0, 1, 0);
        chk("mem", 16'hbeef, MEM.mem[16'h0800]);
        $display("done stack");
    endtask

    task t_limit;
        bus(1, sea_pkg::OFS_SP, 16'h0bfc);
        rq(sea_pkg::OP_PUSH, 0, 0, 0, 16'h0bfc, 1, 0, 0);
        rq(sea_pkg::OP_PUSH, 0, 0, 0, 16'h0bfe, 1, 0, 0);
        rq(sea_pkg::OP_PUSH, 0, 0, 0, 16'h0c00, 1, 0, 1);
        rq(sea_pkg::OP_IND, 4'hf, 0, 0, 16'h0c02, 0, 1, 1);
        rq(sea_pkg::OP_NONE, 0, 0, 0, 16'h0000, 0, 0, 0);
        bus(1, sea_pkg::OFS_SP, 16'h0800);
        rq(sea_pkg::OP_POP, 0, 0, 0, 16'h07fe, 0, 1, 1);
        bus(0, sea_pkg::OFS_STAT, 16'h0);
        chk("stat", 16'h0003, q);
        $display("done limit");
    endtask

    task t_modes;
        wb(4'h3, 16'h1000);
        wb(4'h4, 16'h0010);
        rq(sea_pkg::OP_IND, 3, 0, 0, 16'h1000, 0, 1, 0);
        rq(sea_pkg::OP_POST, 3, 2, 0, 16'h1000, 0, 1, 0);
        rq(sea_pkg::OP_IND, 3, 0, 0, 16'h1002, 0, 1, 0);
        rq(sea_pkg::OP_PRE, 3, 4'hc, 0, 16'h0ffe, 0, 1, 0);
        rq(sea_pkg::OP_INDEX, 3, 0, 0, 16'h100e, 0, 1, 0);
        rq(sea_pkg::OP_LITOFF, 3, 0, 10'h3fe, 16'h0ffc, 0, 1, 0);
        rq(sea_pkg::OP_LIT5, 0, 0, 10'h3f5, 16'h0000, 0, 0, 0);
        chk("op2", 16'h0015, operand2_o);
        chk("op1", 16'h0ffe, operand1_o);
        rq(sea_pkg::OP_LIT10, 0, 0, 10'h2a5, 16'h0000, 0, 0, 0);
        chk("op2", 16'h02a5, operand2_o);
        file_addr_i <= 16'he004;
        rq(sea_pkg::OP_FILE, 0, 0, 0, 16'h0004, 0, 1, 0);
        move_full_i <= 1;
        rq(sea_pkg::OP_FILE, 0, 0, 0, 16'he004, 0, 1, 0);
        $display("done modes");
    endtask

    task t_secure;
        bus(1, sea_pkg::OFS_CTRL, 16'h0003);
        wb(4'h5, 16'h0c10);
        wb(4'h6, 16'h0d20);
        code_in_boot_i <= 1;
        rq(sea_pkg::OP_IND, 5, 0, 0, 16'h0c10, 0, 1, 0);
        chk("refused", 0, refused_o);
        code_in_boot_i <= 0;
        code_in_secure_i <= 1;
        rq(sea_pkg::OP_NONE, 0, 0, 0, 16'h0000, 0, 0, 0);
        rq(sea_pkg::OP_IND, 6, 0, 0, 16'h0d20, 0, 1, 0);
        chk("refused", 0, refused_o);
        rq(sea_pkg::OP_IND, 5, 0, 0, 16'h0c10, 0, 0, 0);
        chk("refused", 1, refused_o);
        code_in_secure_i <= 0;
        rq(sea_pkg::OP_IND, 6, 0, 0, 16'h0d20, 0, 0, 0);
        chk("refused", 1, refused_o);
        $display("done secure");
    endtask

    task print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1;
        repeat (3) @(posedge clk_i);
        t_regs;
        t_stack;
        t_limit;
        t_modes;
        t_secure;
        print_verdict;
    end
endmodule
